//--- rtl/tcp_regs.svh
/*
 register offsets, field positions, reset values and timing counts
 of the transmit cell processor; included by its bare name
*/
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// ****************
// offsets
// ****************
`define TCP_OFS_LOAD_METERS  8'h00
`define TCP_OFS_IDLE_HDR     8'h61
`define TCP_OFS_IDLE_PAY     8'h62
`define TCP_OFS_FIFO_CTRL    8'h63
`define TCP_OFS_CNT_LOW      8'h64
`define TCP_OFS_CNT_MID      8'h65
`define TCP_OFS_CNT_HIGH     8'h66
`define TCP_OFS_CONFIG       8'h67

// ****************
// reset values
// ****************
`define TCP_RST_IDLE_HDR     8'h00
`define TCP_RST_IDLE_PAY     8'h6A
`define TCP_RST_CONFIG       8'h08

// ****************
// fields of fifo control
// ****************
`define TCP_FC_SENSE         7
`define TCP_FC_IRQ_EN        6
`define TCP_FC_ERR           4
`define TCP_FC_DEPTH_HI      3
`define TCP_FC_DEPTH_LO      2
`define TCP_FC_FULL_SEL      1

// ****************
// fields of configuration
// ****************
`define TCP_CF_GFC_HI        7
`define TCP_CF_GFC_LO        4
`define TCP_CF_FIXED_STUFF_ENABLE          3
`define TCP_CF_H4_INS_N      2

// ****************
// cell and spe geometry
// ****************
`define TCP_CELL_BYTES       8'h34
`define TCP_FIFO_BYTES       8'hD0
`define TCP_NEAR_MARGIN      8'h04
`define TCP_STUFF_COL_A      7'h1E
`define TCP_STUFF_COL_B      7'h3B

// ****************
// timing
// ****************
`define TCP_CLK_PERIOD_NS    50
`define TCP_LATCH_VALID_NS   200
`define TCP_LATCH_CYCLES     (`TCP_LATCH_VALID_NS / `TCP_CLK_PERIOD_NS)

`endif

//--- rtl/tcp_pkg.sv
/*
 types shared by the transmit cell processor files
 assumes tcp_regs.svh for all numeric constants
*/
package tcp_pkg;
	typedef logic [7:0] tcp_byte_t;
	typedef enum logic [0:0]
	{
		TCP_SRC_IDLE = 1'b0,
		TCP_SRC_FIFO = 1'b1
	} tcp_src_e;
endpackage : tcp_pkg

//--- rtl/tcp_parity_check.sv
/*
 parity check of one transmit bus byte, registered error pulse
 assumes byte and parity bit are on the same clock
*/
`timescale 1ns/100ps
module tcp_parity_check
(
	// clock and reset
	input  wire logic            i_ref_clk,
	input  wire logic            i_rst_b,
	// byte and check
	input  wire tcp_pkg::tcp_byte_t i_data,
	input  wire logic            i_parity,
	input  wire logic            i_valid,
	input  wire logic            i_even_sense,
	// result
	output logic                 o_error
);
	import tcp_pkg::*;

	logic ones_odd;

	// even sense: total ones even; odd sense: total ones odd
	assign ones_odd = ^{i_data, i_parity};

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_error <= 1'b0;
		else
			o_error <= i_valid && (ones_odd == i_even_sense); // [RULE_14]
	end

	a_parity_detect: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_14]
		i_valid && (^{i_data, i_parity} == i_even_sense) |=> o_error)
		else $error("parity mismatch not reported");
endmodule : tcp_parity_check

//--- rtl/tcp_cell_counter.sv
/*
 saturating cell counter with latch and restart
 assumes count and latch pulses on the same clock
*/
`timescale 1ns/100ps
module tcp_cell_counter
#(
	parameter int WIDTH = 19
)
(
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_b,
	// events
	input  wire logic             i_count,
	input  wire logic             i_latch,
	// latched value
	output logic [WIDTH-1:0]      o_latched
);
	logic [WIDTH-1:0] live;

	if (WIDTH < 1 || WIDTH > 24)
	begin : g_bad_width
		$error("counter width out of range");
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			live <= '0;
		else if (i_latch)
			live <= {{(WIDTH-1){1'b0}}, i_count}; // [RULE_16]
		else if (i_count && live != {WIDTH{1'b1}})
			live <= live + 1'b1; // [RULE_24]
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_latched <= '0;
		else if (i_latch)
			o_latched <= live; // [RULE_16][RULE_17]
	end

	a_latch_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_16]
		i_latch |=> o_latched == $past(live) && live == $past(i_count))
		else $error("latch did not copy or restart");
	a_count_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_24]
		!i_latch && live == {WIDTH{1'b1}} |=> live == {WIDTH{1'b1}})
		else $error("counter wrapped");
endmodule : tcp_cell_counter

//--- rtl/tcp_transmit_cell_processor.sv
/*
 transmit cell processor: four cell fifo, idle cell insertion,
 cell available flag, parity check, cell count, spe byte choice.
 assumes upstream writes and spe byte requests are on i_ref_clk;
 cells are 52 bytes, the header check byte is added downstream.
*/
// The strobed register port is this design's own decision.
// Summary of operation
// RULE_01 - idle cell first octet high nibble comes from idle header flow bits
// RULE_02 - no complete cell waiting means an idle cell is sent instead
// RULE_03 - idle cell path and channel identifier fields are all zero
// RULE_04 - payload type and loss priority fill fourth idle header octet low bits
// RULE_05 - every idle payload octet is the programmed idle payload byte
// RULE_06 - full select: drop when full; else when four or fewer writes left
// RULE_07 - depth field 00..11 sets four, three, two, one cell threshold
// RULE_08 - threshold counts cell being read; rises only after cell read out
// RULE_09 - depth affects only cell available; writes accepted until four cells
// RULE_10 - software should avoid one cell depth; two cells recommended
// RULE_11 - software writes zero to reserved fifo control bits
// RULE_12 - parity mismatch sets error flag; reading fifo control clears it
// RULE_13 - parity interrupt enable routes error flag to active low interrupt
// RULE_14 - parity sense one checks even parity, zero checks odd
// RULE_15 - 19 bit counter counts fifo cells sent, idle cells excluded
// RULE_16 - count register write latches count and restarts at zero or one
// RULE_17 - latched count valid within 200 ns of the trigger write
// RULE_18 - global load meters write also latches the cell count
// RULE_19 - software latches and reads the count about once a second
// RULE_20 - fixed byte field selects 00, 55, AA or FF stuff byte
// RULE_21 - h4 insert low bit one sends zero, else cell offset
// RULE_22 - sts-1 with stuff enabled puts pattern in columns 30 and 59
// RULE_23 - set flow insert bits take flow control bits from serial input
// RULE_24 - internal counter holds at maximum instead of wrapping
`timescale 1ns/100ps
`include "tcp_regs.svh"
module tcp_transmit_cell_processor
(
	// clock and reset
	input  wire logic               i_ref_clk,
	input  wire logic               i_rst_b,
	// register port
	input  wire logic [7:0]         i_reg_addr,
	input  wire tcp_pkg::tcp_byte_t i_reg_wdata,
	input  wire logic               i_reg_wr,
	input  wire logic               i_reg_rd,
	output tcp_pkg::tcp_byte_t      o_reg_rdata,
	// upstream cell writes
	input  wire tcp_pkg::tcp_byte_t i_transmit_data_bus,
	input  wire logic               i_transmit_parity_input,
	input  wire logic               i_tx_write,
	output logic                    o_transmit_cell_available,
	// flow control serial input
	input  wire logic               i_flow_control_serial_in,
	input  wire logic               i_flow_control_shift,
	// spe byte requests
	input  wire logic               i_byte_req,
	input  wire logic               i_byte_is_h4,
	input  wire logic [6:0]         i_spe_column,
	input  wire logic               i_sts1_mode,
	input  wire tcp_pkg::tcp_byte_t i_cell_offset,
	output tcp_pkg::tcp_byte_t      o_spe_byte,
	output logic                    o_spe_valid,
	// interrupt, open drain
	output logic                    o_interrupt_out_n,
	output logic                    o_interrupt_oe
);
	import tcp_pkg::*;

	// ****************
	// registers
	// ****************
	tcp_byte_t        idle_hdr;
	tcp_byte_t        idle_pay;
	tcp_byte_t        config_reg;
	logic             parity_sense_select;
	logic             parity_irq_enable;
	logic [1:0]       fifo_depth_select;
	logic             fill_flag_full_select;
	logic             parity_error_flag;
	logic             parity_error;
	logic             latch_req;
	logic             cnt_event;
	logic [18:0]      transmit_cell_count;
	tcp_byte_t        next_rdata;
	logic             fc_read;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			idle_hdr              <= `TCP_RST_IDLE_HDR;
			idle_pay              <= `TCP_RST_IDLE_PAY;
			config_reg            <= `TCP_RST_CONFIG;
			parity_sense_select   <= 1'b0;
			parity_irq_enable     <= 1'b0;
			fifo_depth_select     <= 2'h0;
			fill_flag_full_select <= 1'b0;
		end
		else if (i_reg_wr)
		begin
			case (i_reg_addr)
				`TCP_OFS_IDLE_HDR: idle_hdr <= i_reg_wdata;
				`TCP_OFS_IDLE_PAY: idle_pay <= i_reg_wdata;
				`TCP_OFS_CONFIG:   config_reg <= i_reg_wdata;
				`TCP_OFS_FIFO_CTRL:
				begin
					parity_sense_select   <= i_reg_wdata[`TCP_FC_SENSE];
					parity_irq_enable     <= i_reg_wdata[`TCP_FC_IRQ_EN];
					fifo_depth_select     <= i_reg_wdata[`TCP_FC_DEPTH_HI:`TCP_FC_DEPTH_LO];
					fill_flag_full_select <= i_reg_wdata[`TCP_FC_FULL_SEL];
				end
				default: ;
			endcase
		end
	end

	// ****************
	// read port
	// ****************
	assign fc_read = i_reg_rd && i_reg_addr == `TCP_OFS_FIFO_CTRL;

	always_comb
	begin
		next_rdata = 8'h00;
		case (i_reg_addr)
			`TCP_OFS_IDLE_HDR:  next_rdata = idle_hdr;
			`TCP_OFS_IDLE_PAY:  next_rdata = idle_pay;
			`TCP_OFS_CONFIG:    next_rdata = config_reg;
			`TCP_OFS_CNT_LOW:   next_rdata = transmit_cell_count[7:0];
			`TCP_OFS_CNT_MID:   next_rdata = transmit_cell_count[15:8];
			`TCP_OFS_CNT_HIGH:  next_rdata = {5'h00, transmit_cell_count[18:16]};
			`TCP_OFS_FIFO_CTRL:
				next_rdata = {parity_sense_select, parity_irq_enable, 1'b0,
					parity_error_flag, fifo_depth_select, fill_flag_full_select, 1'b0};
			default:            next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= next_rdata;
		else
			o_reg_rdata <= 8'h00;
	end

	// ****************
	// parity flag and interrupt
	// ****************
	tcp_parity_check u_parity
	(
		.i_ref_clk    (i_ref_clk),
		.i_rst_b      (i_rst_b),
		.i_data       (i_transmit_data_bus),
		.i_parity     (i_transmit_parity_input),
		.i_valid      (i_tx_write),
		.i_even_sense (parity_sense_select),
		.o_error      (parity_error)
	);

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			parity_error_flag <= 1'b0;
		else if (parity_error)
			parity_error_flag <= 1'b1; // [RULE_12]
		else if (fc_read)
			parity_error_flag <= 1'b0; // [RULE_12]
	end

	assign o_interrupt_out_n = 1'b0;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_interrupt_oe <= 1'b0;
		else
			o_interrupt_oe <= parity_error_flag && parity_irq_enable; // [RULE_13]
	end

	// ****************
	// cell fifo
	// ****************
	tcp_byte_t  mem [0:207];
	logic [7:0] wr_ptr;
	logic [7:0] rd_ptr;
	logic [7:0] occ;
	logic [7:0] wr_idx;
	logic [7:0] out_idx;
	logic [2:0] ready_cells;
	logic [7:0] threshold;
	logic [7:0] depth_bytes;
	logic       wr_acc;
	logic       wr_done;
	logic       rd_take;
	logic       rd_done;
	logic       cell_slot;
	logic       stuff_col;
	tcp_src_e   src;
	tcp_src_e   cur_src;

	assign wr_acc  = i_tx_write && occ < `TCP_FIFO_BYTES; // [RULE_09]
	assign wr_done = wr_acc && wr_idx == `TCP_CELL_BYTES - 8'h01;

	always_ff @(posedge i_ref_clk)
	begin
		if (wr_acc)
			mem[wr_ptr] <= i_transmit_data_bus;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_ptr <= 8'h00;
			wr_idx <= 8'h00;
		end
		else if (wr_acc)
		begin
			wr_ptr <= (wr_ptr == `TCP_FIFO_BYTES - 8'h01) ? 8'h00 : wr_ptr + 8'h01;
			wr_idx <= wr_done ? 8'h00 : wr_idx + 8'h01;
		end
	end

	// ****************
	// cell source selection
	// ****************
	assign stuff_col = i_sts1_mode && config_reg[`TCP_CF_FIXED_STUFF_ENABLE]
		&& (i_spe_column == `TCP_STUFF_COL_A || i_spe_column == `TCP_STUFF_COL_B);
	assign cell_slot = i_byte_req && !i_byte_is_h4 && !stuff_col; // [RULE_22]
	assign cur_src   = (out_idx != 8'h00) ? src
		: (ready_cells != 3'h0) ? TCP_SRC_FIFO : TCP_SRC_IDLE; // [RULE_02]
	assign rd_take   = cell_slot && cur_src == TCP_SRC_FIFO;
	assign rd_done   = rd_take && out_idx == `TCP_CELL_BYTES - 8'h01;
	assign cnt_event = rd_done; // [RULE_15]

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			src     <= TCP_SRC_IDLE;
			out_idx <= 8'h00;
		end
		else if (cell_slot)
		begin
			src     <= cur_src;
			out_idx <= (out_idx == `TCP_CELL_BYTES - 8'h01) ? 8'h00 : out_idx + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rd_ptr <= 8'h00;
		else if (rd_take)
			rd_ptr <= (rd_ptr == `TCP_FIFO_BYTES - 8'h01) ? 8'h00 : rd_ptr + 8'h01;
	end

	// occupancy keeps the cell under read until its last byte leaves
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			occ         <= 8'h00;
			ready_cells <= 3'h0;
		end
		else
		begin
			occ <= occ + {7'h00, wr_acc} - (rd_done ? `TCP_CELL_BYTES : 8'h00); // [RULE_08]
			ready_cells <= ready_cells + {2'h0, wr_done} - {2'h0, rd_done};
		end
	end

	// ****************
	// cell available
	// ****************
	always_comb
	begin
		case (fifo_depth_select)
			2'h0:    depth_bytes = 8'hD0; // [RULE_07]
			2'h1:    depth_bytes = 8'h9C;
			2'h2:    depth_bytes = 8'h68;
			2'h3:    depth_bytes = 8'h34;
			default: depth_bytes = 8'hD0;
		endcase
		threshold = fill_flag_full_select ? depth_bytes
			: depth_bytes - `TCP_NEAR_MARGIN; // [RULE_06]
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_transmit_cell_available <= 1'b0;
		else
			o_transmit_cell_available <= occ < threshold; // [RULE_08]
	end

	// ****************
	// flow control serial bits
	// ****************
	logic [3:0] gfc_serial;
	logic [3:0] gfc_base;
	logic [3:0] gfc_mask;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			gfc_serial <= 4'h0;
		else if (i_flow_control_shift)
			gfc_serial <= {gfc_serial[2:0], i_flow_control_serial_in};
	end

	assign gfc_mask = config_reg[`TCP_CF_GFC_HI:`TCP_CF_GFC_LO];
	assign gfc_base = (cur_src == TCP_SRC_IDLE) ? idle_hdr[7:4] // [RULE_01]
		: mem[rd_ptr][7:4];

	// ****************
	// outgoing byte
	// ****************
	tcp_byte_t next_spe_byte;
	tcp_byte_t fix_byte;

	always_comb
	begin
		case (config_reg[1:0])
			2'h0:    fix_byte = 8'h00; // [RULE_20]
			2'h1:    fix_byte = 8'h55;
			2'h2:    fix_byte = 8'hAA;
			2'h3:    fix_byte = 8'hFF;
			default: fix_byte = 8'h00;
		endcase
	end

	always_comb
	begin
		next_spe_byte = 8'h00;
		if (i_byte_is_h4)
			next_spe_byte = config_reg[`TCP_CF_H4_INS_N] ? 8'h00 : i_cell_offset; // [RULE_21]
		else if (stuff_col)
			next_spe_byte = fix_byte; // [RULE_22]
		else if (out_idx == 8'h00)
			next_spe_byte = {(gfc_mask & gfc_serial) | (~gfc_mask & gfc_base), // [RULE_23]
				(cur_src == TCP_SRC_IDLE) ? 4'h0 : mem[rd_ptr][3:0]};
		else if (cur_src == TCP_SRC_FIFO)
			next_spe_byte = mem[rd_ptr];
		else if (out_idx == 8'h03)
			next_spe_byte = {4'h0, idle_hdr[3:0]}; // [RULE_04]
		else if (out_idx < 8'h03)
			next_spe_byte = 8'h00; // [RULE_03]
		else
			next_spe_byte = idle_pay; // [RULE_05]
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_spe_byte  <= 8'h00;
			o_spe_valid <= 1'b0;
		end
		else
		begin
			o_spe_byte  <= next_spe_byte;
			o_spe_valid <= i_byte_req;
		end
	end

	// ****************
	// cell counter
	// ****************
	assign latch_req = i_reg_wr && (i_reg_addr == `TCP_OFS_CNT_LOW // [RULE_16]
		|| i_reg_addr == `TCP_OFS_CNT_MID || i_reg_addr == `TCP_OFS_CNT_HIGH
		|| i_reg_addr == `TCP_OFS_LOAD_METERS); // [RULE_18]

	tcp_cell_counter #(.WIDTH(19)) u_count
	(
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.i_count   (cnt_event),
		.i_latch   (latch_req),
		.o_latched (transmit_cell_count)
	);

	// ****************
	// checks
	// ****************

	sequence s_idle_slot(logic [7:0] idx);
		cell_slot && cur_src == TCP_SRC_IDLE && out_idx == idx;
	endsequence

	sequence s_reg_read(logic [7:0] a);
		i_reg_rd && i_reg_addr == a;
	endsequence

	a_idle_vpi_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_03]
		cell_slot && cur_src == TCP_SRC_IDLE && (out_idx == 8'h01 || out_idx == 8'h02)
		|=> o_spe_byte == 8'h00)
		else $error("idle header identifier not zero");
	a_idle_octet_four: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_04]
		s_idle_slot(8'h03) |=> o_spe_byte == {4'h0, $past(idle_hdr[3:0])})
		else $error("idle fourth octet wrong");
	a_idle_payload: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_05]
		s_idle_slot(8'h10) |=> o_spe_byte == $past(idle_pay))
		else $error("idle payload octet wrong");
	a_idle_on_empty: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_02]
		cell_slot && out_idx == 8'h00 && ready_cells == 3'h0 |=> src == TCP_SRC_IDLE)
		else $error("fifo cell started with none complete");
	a_avail_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_06]
		fill_flag_full_select && fifo_depth_select == 2'h0 && occ == 8'hD0
		|=> !o_transmit_cell_available)
		else $error("cell available high while full");
	a_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_09]
		occ <= `TCP_FIFO_BYTES && ready_cells <= 3'h4)
		else $error("fifo overfilled");
	a_parity_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_12]
		parity_error |=> parity_error_flag ##1 o_interrupt_oe == $past(parity_irq_enable))
		else $error("parity flag or interrupt not raised");
	a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_12]
		s_reg_read(`TCP_OFS_FIFO_CTRL) && !parity_error |=> !parity_error_flag)
		else $error("read did not clear parity flag");
	a_irq_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_13]
		!parity_irq_enable [*2] |-> !o_interrupt_oe)
		else $error("interrupt while disabled");
	a_h4_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_21]
		i_byte_req && i_byte_is_h4 && config_reg[`TCP_CF_H4_INS_N] |=> o_spe_byte == 8'h00)
		else $error("h4 not zero");
	a_stuff_byte: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_22]
		i_byte_req && !i_byte_is_h4 && stuff_col && config_reg[1:0] == 2'h2
		|=> o_spe_byte == 8'hAA)
		else $error("fixed stuff byte wrong");
	a_count_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE_17]
		latch_req ##1 !latch_req [*4] |-> $stable(transmit_cell_count))
		else $error("latched count not settled");
endmodule : tcp_transmit_cell_processor

//--- verification/atm_layer_source.sv
/*
 upstream cell source model: writes whole 52 byte cells
 assumes the bench gives it the parity sense in force
*/
`timescale 1ns/100ps
module atm_layer_source
(
	// clock
	input  wire logic          i_ref_clk,
	// parity sense, high = even
	input  wire logic          i_even,
	// cell byte bus
	output tcp_pkg::tcp_byte_t o_data,
	output logic               o_parity,
	output logic               o_write
);
	import tcp_pkg::*;
	initial
	begin
		o_data = 8'h00;
		o_parity = 1'b0;
		o_write = 1'b0;
	end
	// bytes base..base+51, bad parity on every byte if asked
	task automatic send_cell(input tcp_byte_t base, input logic bad);
		for (int i = 0; i < 52; i++)
		begin
			@(posedge i_ref_clk);
			o_data <= base + 8'(i);
			o_parity <= (^(base + 8'(i))) ^ ~i_even ^ bad;
			o_write <= 1'b1;
		end
		@(posedge i_ref_clk);
		// released bus shows no stale value
		o_data <= ~o_data;
		o_parity <= ~o_parity;
		o_write <= 1'b0;
	endtask : send_cell
endmodule : atm_layer_source

//--- verification/atm_transmit_cell_processor_bench.sv
/*
 self checking bench of the transmit cell processor
 assumes the source model and the design files compiled first
*/
`timescale 1ns/100ps
module atm_transmit_cell_processor_bench;
	import tcp_pkg::*;
	logic       clk, rst_b, wr, rd, req, h4, sts1, fshift, fser, even;
	logic [7:0] addr;
	logic [6:0] col;
	tcp_byte_t  wdata, rdata, offs, sdata, sbyte;
	logic       spar, swr, ca, svalid, irq_n, irq_oe;
	int         fail_count, n_compared, cyc;

	tcp_transmit_cell_processor dut
	(
		.i_ref_clk                (clk),
		.i_rst_b                  (rst_b),
		.i_reg_addr               (addr),
		.i_reg_wdata              (wdata),
		.i_reg_wr                 (wr),
		.i_reg_rd                 (rd),
		.o_reg_rdata              (rdata),
		.i_transmit_data_bus      (sdata),
		.i_transmit_parity_input  (spar),
		.i_tx_write               (swr),
		.o_transmit_cell_available(ca),
		.i_flow_control_serial_in (fser),
		.i_flow_control_shift     (fshift),
		.i_byte_req               (req),
		.i_byte_is_h4             (h4),
		.i_spe_column             (col),
		.i_sts1_mode              (sts1),
		.i_cell_offset            (offs),
		.o_spe_byte               (sbyte),
		.o_spe_valid              (svalid),
		.o_interrupt_out_n        (irq_n),
		.o_interrupt_oe           (irq_oe)
	);
	atm_layer_source src
	(
		.i_ref_clk(clk),
		.i_even   (even),
		.o_data   (sdata),
		.o_parity (spar),
		.o_write  (swr)
	);

	// ****************
	// clock, timeout, report
	// ****************
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic chk(input tcp_byte_t seen, input tcp_byte_t exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// ****************
	// access tasks
	// ****************
	task automatic reg_wr(input logic [7:0] a, input tcp_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input tcp_byte_t e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : reg_rd
	task automatic spe(input logic [6:0] c, input logic h, input tcp_byte_t e);
		@(posedge clk);
		req <= 1'b1;
		col <= c;
		h4 <= h;
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk({7'h00, svalid}, 8'h01);
		chk(sbyte, e);
	endtask : spe
	// sel 0 watches cell available, else interrupt output enable
	task automatic settle_flag(input int sel, input tcp_byte_t e);
		repeat (3) @(posedge clk);
		#1;
		chk({7'h00, (sel == 0) ? ca : irq_oe}, e);
	endtask : settle_flag
	function automatic tcp_byte_t idle_exp(input int i);
		return (i == 0) ? 8'hA0 : (i == 3) ? 8'h05 : (i < 4) ? 8'h00 : 8'h3C;
	endfunction : idle_exp

	// ****************
	// tests
	// ****************
	initial
	begin
		rst_b = 1'b0;
		{wr, rd, req, h4, sts1, fshift, fser, even} = 8'h00;
		addr = 8'h00;
		wdata = 8'h00;
		col = 7'h01;
		offs = 8'h2B;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		reg_rd(8'h61, 8'h00);
		reg_rd(8'h62, 8'h6A);
		reg_rd(8'h63, 8'h00);
		reg_rd(8'h67, 8'h08);
		reg_rd(8'h70, 8'h00);
		reg_wr(8'h61, 8'hA5);
		reg_wr(8'h62, 8'h3C);
		reg_rd(8'h61, 8'hA5);
		for (int i = 0; i < 52; i++)
			spe(7'h01, 1'b0, idle_exp(i));
		reg_wr(8'h64, 8'hFF);
		reg_rd(8'h64, 8'h00);
		// two cell depth, odd parity, interrupt on
		reg_wr(8'h63, 8'h48);
		src.send_cell(8'h10, 1'b0);
		settle_flag(0, 8'h01);
		src.send_cell(8'h50, 1'b0);
		settle_flag(0, 8'h00);
		src.send_cell(8'h90, 1'b1);
		settle_flag(1, 8'h01);
		chk({7'h00, irq_n}, 8'h00);
		reg_rd(8'h63, 8'h58);
		reg_rd(8'h63, 8'h48);
		settle_flag(1, 8'h00);
		// even sense, interrupt off
		reg_wr(8'h63, 8'h88);
		even <= 1'b1;
		src.send_cell(8'hD0, 1'b0);
		reg_rd(8'h63, 8'h88);
		src.send_cell(8'hE0, 1'b1);
		settle_flag(1, 8'h00);
		reg_rd(8'h63, 8'h98);
		// full select, four cell depth: a full fifo drops the flag
		reg_wr(8'h63, 8'h82);
		settle_flag(0, 8'h00);
		reg_wr(8'h63, 8'h88);
		for (int k = 0; k < 4; k++)
		begin
			for (int i = 0; i < 52; i++)
				spe(7'h01, 1'b0, 8'h10 + 8'(k * 64) + 8'(i));
			settle_flag(0, {7'h00, k >= 2});
		end
		reg_wr(8'h00, 8'h00);
		reg_rd(8'h64, 8'h04);
		reg_rd(8'h65, 8'h00);
		reg_rd(8'h66, 8'h00);
		reg_wr(8'h65, 8'h33);
		reg_rd(8'h64, 8'h00);
		sts1 <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			reg_wr(8'h67, 8'h08 | 8'(k));
			spe(7'h1E, 1'b0, 8'(k * 85));
			spe(7'h3B, 1'b0, 8'(k * 85));
		end
		spe(7'h01, 1'b1, 8'h2B);
		reg_wr(8'h67, 8'h0C);
		spe(7'h01, 1'b1, 8'h00);
		// serial flow bits 1100 into the two upper places
		reg_wr(8'h67, 8'hC0);
		for (int i = 3; i >= 0; i--)
		begin
			@(posedge clk);
			fser <= (i >= 2);
			fshift <= 1'b1;
		end
		@(posedge clk);
		fshift <= 1'b0;
		spe(7'h1E, 1'b0, 8'hE0);
		end_sim();
	end
endmodule : atm_transmit_cell_processor_bench
